// [verilog/epmd_pkg.sv]
// Package for the encoder pulse multiplier and divider
package epmd_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 10000000;

  // Divider switch bank
  localparam int unsigned SW_WIDTH = 8;
  localparam logic [7:0] DIV_DEFAULT = 8'h01;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  localparam logic [7:0] DIV_ONE = 8'h01;

  // Full-scale divided rate for the conversion stage
  localparam int unsigned FULL_SCALE_HZ = 500;
  localparam int unsigned FULL_SCALE_CYCLES = CLK_HZ / FULL_SCALE_HZ;

  // Raw channel samples
  typedef struct packed {
    logic chan_b;
    logic chan_a;
  } epmd_chan_t;

  // Divided pulse output
  typedef struct packed {
    logic pulse;
    logic [7:0] ratio;
  } epmd_out_t;

endpackage : epmd_pkg

// [verilog/epmd_edge_doubler.sv]
// Synchroniser and both-edge pulse generator for one encoder channel
`timescale 1ns/1ps
module epmd_edge_doubler
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel
  input wire logic chan_in,
  input wire logic enable,
  output logic edge_pulse
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // Pin is asynchronous to clk
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= chan_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prev_reg <= 1'b0;
    else
      prev_reg <= sync2_reg;
  end

  // Rising and falling edges both count
  assign edge_pulse = enable & (sync2_reg ^ prev_reg); // [R01]

endmodule : epmd_edge_doubler

// [verilog/epmd_top.sv]
// Encoder pulse doubler, merger and switch-set divider
// Notes on behaviour
// [R01] Each channel yields a pulse on both its rising and falling edges.
// [R02] Encoder keeps each channel near half duty so doubled pulses stay even.
// [R03] Second channel lags the first by a quarter period, keeping edges distinct.
// [R04] Doubled streams merge into one, four times rate with both channels.
// [R05] Merged stream is divided by an eight-switch integer from 1 to 255.
// [R06] Divided pulses go to the conversion stage; 500 per second is full scale.
// [R07] Switch one weighs one, switch eight weighs one hundred twenty-eight.
// [R08] Shipped setting divides by one, passing merged pulses unchanged.
// [R09] One output per N merged pulses; counter clears at reset; zero acts as one.
`timescale 1ns/1ps
module epmd_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Encoder channels, isolated pins
  input wire epmd_pkg::epmd_chan_t chan,
  input wire logic chan_b_used,
  // Divider switches, bit 0 is switch one
  input wire logic [7:0] div_switch,
  // Conversion stage
  output epmd_pkg::epmd_out_t conv_out,
  output logic merged_pulse
);

  // Doubled edges, one per channel
  logic edge_a;
  logic edge_b;
  logic en_a;
  logic en_b;
  logic [2:0] arm_reg;

  // Switch bank and channel-select synchronisers
  logic [7:0] sw_meta_reg;
  logic [7:0] sw_reg;
  logic used_meta_reg;
  logic used_reg;

  // Ratio in force, held in a flop so the output is registered
  logic [7:0] ratio_next;
  logic [7:0] ratio_reg;

  // Merge stage
  logic [1:0] edge_total;
  logic [2:0] merge_total;
  logic [1:0] backlog_reg;
  logic [1:0] backlog_next;

  // Divider
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic hit;
  logic pulse_reg;

  // Zero switch setting would divide by 256
  function automatic logic [7:0] clamp_ratio(input logic [7:0] raw);
    clamp_ratio = (raw == epmd_pkg::DIV_ZERO) ? epmd_pkg::DIV_ONE : raw; // [R09]
  endfunction : clamp_ratio

  // Number of doubled edges arriving in one cycle
  function automatic logic [1:0] edge_sum(input logic a, input logic b);
    edge_sum = {1'b0, a} + {1'b0, b};
  endfunction : edge_sum

  // Terminal count; a ratio lowered mid-count fires on the next merged pulse
  function automatic logic div_reached(input logic [7:0] cnt, input logic [7:0] n);
    div_reached = (cnt >= n - 8'h01);
  endfunction : div_reached

  // A pin already high at release must not look like an edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      arm_reg <= 3'h0;
    end
    else
    begin
      arm_reg <= {arm_reg[1:0], 1'b1}; // [R01]
    end
  end

  // Edges before the synchronisers have filled are dropped (limitation)
  assign en_a = arm_reg[2];
  assign en_b = arm_reg[2] & used_reg;

  epmd_edge_doubler u_dbl_a
  (
    .clk(clk),
    .rst(rst),
    .chan_in(chan.chan_a),
    .enable(en_a),
    .edge_pulse(edge_a)
  );

  epmd_edge_doubler u_dbl_b
  (
    .clk(clk),
    .rst(rst),
    .chan_in(chan.chan_b),
    .enable(en_b),
    .edge_pulse(edge_b)
  );

  // Switches are static levels from outside the clock domain
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sw_meta_reg <= epmd_pkg::DIV_DEFAULT;
      sw_reg <= epmd_pkg::DIV_DEFAULT; // [R08]
    end
    else
    begin
      sw_meta_reg <= div_switch;
      sw_reg <= sw_meta_reg; // [R07]
    end
  end

  // Channel-select level, synchronised the same way
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      used_meta_reg <= 1'b0;
      used_reg <= 1'b0;
    end
    else
    begin
      used_meta_reg <= chan_b_used;
      used_reg <= used_meta_reg;
    end
  end

  assign ratio_next = clamp_ratio(sw_reg); // [R05]

  // A switch change takes effect three cycles later
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ratio_reg <= epmd_pkg::DIV_DEFAULT; // [R08]
    end
    else
    begin
      ratio_reg <= ratio_next;
    end
  end

  assign edge_total = edge_sum(edge_a, edge_b);

  // Coincident A and B edges: the second waits a cycle instead of being lost
  always_comb
  begin
    merge_total = {1'b0, backlog_reg} + {1'b0, edge_total};
    merged_pulse = (merge_total != 3'h0); // [R04]
    if (merge_total > 3'h3)
      backlog_next = 2'h3;
    else if (merge_total > 3'h1)
      backlog_next = merge_total[1:0] - 2'h1;
    else
      backlog_next = 2'h0;
  end

  // Backlog stays at one or less while each pin holds a level two cycles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      backlog_reg <= 2'h0;
    end
    else
    begin
      backlog_reg <= backlog_next;
    end
  end

  always_comb
  begin
    count_next = count_reg;
    hit = 1'b0;
    if (merged_pulse)
    begin
      if (div_reached(count_reg, ratio_reg))
      begin
        count_next = 8'h00;
        hit = 1'b1; // [R09]
      end
      else
        count_next = count_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= 8'h00; // [R09]
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pulse_reg <= 1'b0;
    end
    else
    begin
      pulse_reg <= hit; // [R06]
    end
  end

  // Pulse in the top bit, ratio below
  assign conv_out = {pulse_reg, ratio_reg};

endmodule : epmd_top

// [bench/epmd_props.sv]
// Port checker for the pulse divider
`timescale 1ns/1ps
module epmd_props
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and outputs
  input wire epmd_pkg::epmd_chan_t chan,
  input wire logic chan_b_used,
  input wire logic [7:0] div_switch,
  input wire epmd_pkg::epmd_out_t conv_out,
  input wire logic merged_pulse
);
  logic [8:0] n;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Merged pulses since the last divided pulse
  always_ff @(posedge clk or posedge rst)
    if (rst)
      n <= 9'h000;
    else
      n <= (conv_out.pulse ? 9'h000 : n) + 9'(merged_pulse);
  property p_a; $changed(chan.chan_a) |-> ##[1:4] merged_pulse; endproperty
  a_a: assert property (p_a) else $error("A edge lost");
  property p_b; chan_b_used && $changed(chan.chan_b) |-> ##[1:4] merged_pulse; endproperty
  a_b: assert property (p_b) else $error("B edge lost");
  property p_div; conv_out.pulse |-> n == {1'b0, conv_out.ratio}; endproperty
  a_div: assert property (p_div) else $error("bad count");
  property p_len; conv_out.pulse && conv_out.ratio != 8'h01 |=> !conv_out.pulse; endproperty
  a_len: assert property (p_len) else $error("long pulse");
  property p_sw; $stable(div_switch)[*4] |-> conv_out.ratio == (div_switch == 8'h00 ? 8'h01 : div_switch); endproperty
  a_sw: assert property (p_sw) else $error("bad ratio");
  property p_rst; $fell(rst) |-> conv_out.ratio == 8'h01 && !conv_out.pulse; endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_one; merged_pulse && conv_out.ratio == 8'h01 |=> conv_out.pulse; endproperty
  a_one: assert property (p_one) else $error("no pass");
  c_max: cover property (conv_out.pulse && conv_out.ratio == 8'hFF);
  c_b: cover property (chan_b_used && merged_pulse);
  c_one: cover property (conv_out.pulse && conv_out.ratio == 8'h01);
endmodule : epmd_props
bind epmd_top epmd_props u_epmd_props (.clk(clk), .rst(rst), .chan(chan), .chan_b_used(chan_b_used),
  .div_switch(div_switch), .conv_out(conv_out), .merged_pulse(merged_pulse));

// [bench/epmd_encoder_model.sv]
// Quadrature encoder model
`timescale 1ns/1ps
module epmd_encoder_model
(
  // Clock, run and pins
  input wire logic clk,
  input wire logic run,
  output epmd_pkg::epmd_chan_t chan
);
  int t = 0;
  initial chan = 2'h0;
  // Quarter-period steps keep half duty and B a quarter behind A
  always @(negedge clk)
  begin
    t <= run ? t + 1 : 0;
    if (run && t % 4 == 3)
      chan <= chan.chan_a == chan.chan_b ? chan ^ 2'h1 : chan ^ 2'h2;
  end
endmodule : epmd_encoder_model

// [bench/epmd_top_bench.sv]
// Bench for the pulse multiplier and divider
`timescale 1ns/1ps
module epmd_top_bench;
  logic clk = 0, rst = 1, run = 0, used = 0, merged;
  logic [7:0] sw = 8'h01;
  epmd_pkg::epmd_chan_t chan;
  epmd_pkg::epmd_out_t conv_out;
  int n_mismatch = 0, compares = 0;
  logic [15:0] m, p;
  always #50 clk = ~clk;
  epmd_encoder_model u_epmd_encoder_model (.clk(clk), .run(run), .chan(chan));
  epmd_top u_epmd_top (.clk(clk), .rst(rst), .chan(chan), .chan_b_used(used), .div_switch(sw),
    .conv_out(conv_out), .merged_pulse(merged));
  task check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %0t got %0d want %0d", $time, got, exp);
    end
  endtask : check
  task end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Reset with new switches, then count merged and divided pulses
  task run_case(input logic [7:0] s, input logic u, input int steps);
    rst <= 1;
    sw <= s;
    used <= u;
    m = 16'h0000;
    p = 16'h0000;
    repeat (2) @(negedge clk);
    rst <= 0;
    run <= 1;
    for (int i = 0; i < steps * 4 + 10; i++)
    begin
      @(negedge clk);
      m += merged;
      p += conv_out.pulse;
      if (i == steps * 4 - 1)
        run <= 0;
    end
  endtask : run_case
  // An edge count one past a multiple of four leaves channel A high for the next reset
  task t_pass;
    run_case(8'h01, 1'b1, 13);
    check(m, 16'h000D);
    check(p, 16'h000D);
  endtask : t_pass
  // Released with A high: no false edge may be counted
  task t_zero;
    run_case(8'h00, 1'b0, 24);
    check(m, 16'h000C);
    check(p, 16'h000C);
    check(conv_out.ratio, 16'h0001);
  endtask : t_zero
  task t_max;
    run_case(8'hFF, 1'b1, 300);
    check(m, 16'h012C);
    check(p, 16'h0001);
    check(conv_out.ratio, 16'h00FF);
  endtask : t_max
  initial
  begin
    t_pass();
    t_zero();
    t_max();
    end_of_test();
  end
  initial
  begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule : epmd_top_bench
